//--- hdl/ecct_timer.sv
// Purpose: 16-bit up-counter with two capture/compare registers.
// Assumes: Edge pins are asynchronous; registers sit on a plain word port.
// Notes:   Interrupt requests are one-cycle pulses for an outside controller.
//
// Operation
// [R1] Input A edge captures register one, clears counter.
// [R2] Match zero raises irq zero, toggles output.
// [R3] Register one capture raises irq one.
// [R4] Edge toggle plus match gives compare+1 pulse.
// [R5] Rise clears, fall captures register zero.
// [R6] Reverse-phase capture raises no irq zero.
// [R7] Input B edge still raises irq zero.
// [R8] Software masks unused irq zero.
// [R9] Output unusable while input B detection used.
// [R10] Both edges capture, clear and toggle.
// [R11] Software reads both captures after irq one.
// [R12] Compare matches raise irqs, never clear; here mode 11 clears the counter on a register zero match.
// [R13] Register zero captures on A or B.
// [R14] Register one captures on input A only.
// [R15] Count register reads current count.
// [R16] Mode 01 counts up freely.
// [R17] After maximum: set flag, wrap, continue.
// [R18] Software clears wrap flag by writing zero.
// [R19] Free-running supports all three role mixes.
// [R20] Mode 10 selects edge clear-and-start.
// [R21] Mode bit 1 enables toggle on A edge.
// [R22] Edges accepted after two agreeing samples.
// [R23] Software never counts input A edges here.
// [R24] Reset clears counter, flag, irqs, output.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
module ecct_timer
    import ecct_pkg::*;
#(
    parameter int DIV_MID  = 4,
    parameter int DIV_SLOW = 16
) (
    // Clock and reset
    input  wire logic                   clock_in,
    input  wire logic                   rst_b_in,
    // Register port
    input  wire logic [ECCT_ADDR_W-1:0] addr_in,
    input  wire logic [ECCT_DATA_W-1:0] wr_data_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic      [ECCT_DATA_W-1:0] rd_data_out,
    // Pins
    input  wire logic                   edge_input_a_in,
    input  wire logic                   edge_input_b_in,
    output logic                        toggle_output_out,
    // Interrupt requests
    output logic                        irq_zero_out,
    output logic                        irq_one_out
);
    logic [ECCT_CNT_W-1:0] up_counter_reg;
    logic [ECCT_CNT_W-1:0] cc_register_zero_reg;
    logic [ECCT_CNT_W-1:0] cc_register_one_reg;
    logic [7:1]            mode_control_reg;
    logic                  wrap_flag_reg;
    logic [7:0]            capture_role_reg;
    logic [7:0]            output_control_reg;
    logic [7:0]            prescaler_reg;
    logic [7:0]            div_count_reg;
    logic                  updated_reg;
    logic                  a_rise;
    logic                  a_fall;
    logic                  b_rise;
    logic                  b_fall;
    logic                  a_valid;
    logic                  a_reverse;
    logic                  b_valid;
    logic                  tick;
    logic                  edge_clear;
    logic                  match0;
    logic                  match1;
    logic                  cap0_rev;
    logic                  cap0_b;
    logic                  cap1;
    logic                  toggle_now;
    logic                  wr_mode;
    logic [1:0]            op_mode;
    logic [1:0]            sel_a;
    logic [1:0]            sel_b;
    logic [1:0]            source;

    ecct_edge_sync u_sync_a (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .pin_in   (edge_input_a_in),
        .rise_out (a_rise),
        .fall_out (a_fall)
    );

    ecct_edge_sync u_sync_b (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .pin_in   (edge_input_b_in),
        .rise_out (b_rise),
        .fall_out (b_fall)
    );

    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        edge_hit = (sel == ECCT_EDGE_RISE && r) || (sel == ECCT_EDGE_FALL && f)
                || (sel == ECCT_EDGE_BOTH && (r || f));
    endfunction : edge_hit

    assign op_mode  = mode_control_reg[ECCT_MODE_HI:ECCT_MODE_LO];
    assign sel_a    = prescaler_reg[ECCT_PRE_A_HI:ECCT_PRE_A_LO];
    assign sel_b    = prescaler_reg[ECCT_PRE_B_HI:ECCT_PRE_B_LO];
    assign source   = prescaler_reg[ECCT_PRE_SRC_HI:ECCT_PRE_SRC_LO];
    assign a_valid  = edge_hit(sel_a, a_rise, a_fall);
    // The reverse phase of a single-edge selection is the opposite edge.
    assign a_reverse = edge_hit(sel_a, a_fall, a_rise); // R5
    assign b_valid  = edge_hit(sel_b, b_rise, b_fall); // R22
    assign wr_mode  = wr_in && addr_in == ECCT_ADDR_MODE;

    // Count clock: every cycle, two divided rates, or input A edges.
    always_comb begin
        case (source)
            2'h0:            tick = 1'b1;
            2'h1:            tick = div_count_reg == 8'(DIV_MID - 1);
            2'h2:            tick = div_count_reg == 8'(DIV_SLOW - 1);
            ECCT_SRC_EDGE_A: tick = a_valid;
            default:         tick = 1'b0;
        endcase
    end

    // The divider rests at zero while stopped, so the first divided tick is a full period.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_count_reg <= 8'h00;
        end else if (op_mode == ECCT_OP_STOP || div_count_reg == 8'(DIV_SLOW - 1)) begin
            div_count_reg <= 8'h00;
        end else if (source == 2'h1 && div_count_reg == 8'(DIV_MID - 1)) begin
            div_count_reg <= 8'h00;
        end else begin
            div_count_reg <= div_count_reg + 8'h01;
        end
    end

    // In edge-clear mode an input A edge count source keeps the counter at zero.
    assign edge_clear = op_mode == ECCT_OP_EDGE_CLR && a_valid; // R20 R23
    // Matches are judged once per new count so a held value fires once.
    assign match0 = !capture_role_reg[ECCT_ROLE_CAP0] && updated_reg
                 && up_counter_reg == cc_register_zero_reg;
    assign match1 = !capture_role_reg[ECCT_ROLE_CAP1] && updated_reg
                 && up_counter_reg == cc_register_one_reg;
    assign cap0_rev = capture_role_reg[ECCT_ROLE_CAP0] && capture_role_reg[ECCT_ROLE_REV0]
                   && a_reverse;
    assign cap0_b   = capture_role_reg[ECCT_ROLE_CAP0] && !capture_role_reg[ECCT_ROLE_REV0]
                   && b_valid;
    assign cap1     = capture_role_reg[ECCT_ROLE_CAP1] && a_valid;

    // Stop holds the counter at zero, so every start counts from zero.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            up_counter_reg <= ECCT_CNT_ZERO; // R24
            updated_reg    <= 1'b0;
        end else begin
            updated_reg <= 1'b0;
            if (op_mode == ECCT_OP_STOP) begin
                up_counter_reg <= ECCT_CNT_ZERO;
            end else if (edge_clear) begin
                up_counter_reg <= ECCT_CNT_ZERO; // R1 R10
                updated_reg    <= 1'b1;
            end else if (tick) begin
                updated_reg <= 1'b1;
                // Only a register zero match clears, and only in the match-clear mode.
                if (op_mode == ECCT_OP_MATCH_CLR && match0) begin
                    up_counter_reg <= ECCT_CNT_ZERO; // R12
                end else begin
                    up_counter_reg <= up_counter_reg + 16'h0001; // R16 R17
                end
            end
        end
    end

    // Capture registers; a software write loses against a capture.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cc_register_zero_reg <= ECCT_CNT_ZERO;
            cc_register_one_reg  <= ECCT_CNT_ZERO;
        end else begin
            if (cap0_rev || cap0_b) begin
                cc_register_zero_reg <= up_counter_reg; // R5 R13 R19
            end else if (wr_in && addr_in == ECCT_ADDR_CC0) begin
                cc_register_zero_reg <= wr_data_in;
            end
            if (cap1) begin
                cc_register_one_reg <= up_counter_reg; // R1 R14 R10
            end else if (wr_in && addr_in == ECCT_ADDR_CC1) begin
                cc_register_one_reg <= wr_data_in;
            end
        end
    end

    // Input B raises irq zero even when it captures nothing.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_zero_out <= 1'b0; // R24
            irq_one_out  <= 1'b0;
        end else begin
            irq_zero_out <= match0 || b_valid; // R2 R6 R7 R12
            irq_one_out  <= match1 || cap1; // R3 R12
        end
    end

    // Several events in one cycle give a single toggle.
    assign toggle_now = output_control_reg[ECCT_OUT_EN]
        && ((match0 && output_control_reg[ECCT_OUT_INV0])
         || (match1 && output_control_reg[ECCT_OUT_INV1])
         || (op_mode != ECCT_OP_STOP && a_valid && mode_control_reg[ECCT_MODE_ETOG]));

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            toggle_output_out <= 1'b0; // R24
        end else if (!output_control_reg[ECCT_OUT_EN]) begin
            toggle_output_out <= 1'b0;
        end else if (toggle_now) begin
            toggle_output_out <= ~toggle_output_out; // R2 R4 R21 R10
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_control_reg      <= 7'h00;
            capture_role_reg      <= 8'h00;
            output_control_reg    <= 8'h00;
            prescaler_reg         <= 8'h00;
        end else if (wr_in) begin
            case (addr_in)
                ECCT_ADDR_MODE:   mode_control_reg      <= wr_data_in[7:1];
                ECCT_ADDR_ROLE:   capture_role_reg      <= wr_data_in[7:0];
                ECCT_ADDR_OUTCTL: output_control_reg    <= wr_data_in[7:0];
                ECCT_ADDR_PRESC:  prescaler_reg         <= wr_data_in[7:0];
                default:          ;
            endcase
        end
    end

    // The wrap flag is set by hardware and only cleared by software; set wins.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wrap_flag_reg <= 1'b0; // R24
        end else if (op_mode != ECCT_OP_STOP && !edge_clear && tick
                     && up_counter_reg == ECCT_CNT_MAX) begin
            wrap_flag_reg <= 1'b1; // R17
        end else if (wr_mode && !wr_data_in[ECCT_MODE_WRAP]) begin
            wrap_flag_reg <= 1'b0; // R18
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_out <= 16'h0000;
        end else if (rd_in) begin
            case (addr_in)
                ECCT_ADDR_MODE:   rd_data_out <= {8'h00, mode_control_reg, wrap_flag_reg};
                ECCT_ADDR_ROLE:   rd_data_out <= {8'h00, capture_role_reg};
                ECCT_ADDR_OUTCTL: rd_data_out <= {8'h00, output_control_reg};
                ECCT_ADDR_PRESC:  rd_data_out <= {8'h00, prescaler_reg};
                ECCT_ADDR_COUNT:  rd_data_out <= up_counter_reg; // R15
                ECCT_ADDR_CC0:    rd_data_out <= cc_register_zero_reg;
                ECCT_ADDR_CC1:    rd_data_out <= cc_register_one_reg;
                default:          rd_data_out <= 16'h0000;
            endcase
        end else begin
            rd_data_out <= 16'h0000;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    // Effects of a cycle's events are checked at the next edge, where they stand.

    chk_edge_clear: assert property (edge_clear |=> up_counter_reg == ECCT_CNT_ZERO) // R1
        else $error("Counter not cleared after input A edge.");

    chk_cap_one: assert property (cap1 |=> cc_register_one_reg == $past(up_counter_reg)) // R14
        else $error("Register one did not capture the count.");

    chk_irq_one_cap: assert property (edge_clear && cap1 |=> irq_one_out) // R3
        else $error("Capture into register one raised no irq one.");

    chk_match_irq: assert property (match0 |=> irq_zero_out) // R2
        else $error("Match on register zero raised no irq zero.");

    chk_rev_quiet: assert property (cap0_rev && !b_valid && !match0 |=> !irq_zero_out) // R6
        else $error("Reverse-phase capture raised irq zero.");

    chk_b_irq: assert property (b_valid |=> irq_zero_out) // R7
        else $error("Input B edge raised no irq zero.");

    chk_free_count: assert property (op_mode == ECCT_OP_FREE && tick && !wr_mode
        |=> up_counter_reg == $past(up_counter_reg) + 16'h0001) // R16
        else $error("Free-running counter did not advance by one.");

    chk_wrap_set: assert property (op_mode == ECCT_OP_FREE && tick
        && up_counter_reg == ECCT_CNT_MAX
        |=> up_counter_reg == ECCT_CNT_ZERO && wrap_flag_reg) // R17
        else $error("Counter did not wrap with the flag set.");

    chk_edge_toggle: assert property (toggle_now // R4
        |=> toggle_output_out != $past(toggle_output_out))
        else $error("Output did not toggle on its event.");

    chk_reset_clear: assert property (@(posedge clock_in) disable iff (1'b0) // R24
        !rst_b_in |=> up_counter_reg == ECCT_CNT_ZERO && !wrap_flag_reg
        && !irq_zero_out && !irq_one_out && !toggle_output_out)
        else $error("Reset left the counter, flag or an output set.");

    chk_irq_zero_src: assert property (!match0 && !b_valid |=> !irq_zero_out) // R6
        else $error("Irq zero rose with no match and no input B edge.");

    chk_irq_one_match: assert property (match1 |=> irq_one_out) // R12
        else $error("Match on register one raised no irq one.");

    chk_rev_capture: assert property (cap0_rev // R5
        |=> cc_register_zero_reg == $past(up_counter_reg))
        else $error("Reverse-phase edge did not capture into register zero.");

    chk_b_capture: assert property (cap0_b // R13
        |=> cc_register_zero_reg == $past(up_counter_reg))
        else $error("Input B edge did not capture into register zero.");

    chk_b_no_capture: assert property (capture_role_reg[ECCT_ROLE_REV0] && b_valid // R7
        && !cap0_rev && !(wr_in && addr_in == ECCT_ADDR_CC0)
        |=> $stable(cc_register_zero_reg))
        else $error("Input B edge changed register zero.");

    chk_one_a_only: assert property (!cap1 && !(wr_in && addr_in == ECCT_ADDR_CC1) // R14
        |=> $stable(cc_register_one_reg))
        else $error("Register one changed with no capture or write.");

    chk_edge_count: assert property (op_mode == ECCT_OP_EDGE_CLR && tick && !edge_clear // R20
        && !wr_mode |=> up_counter_reg == $past(up_counter_reg) + 16'h0001)
        else $error("Edge clear mode counter did not advance by one.");

    chk_toggle_hold: assert property (output_control_reg[ECCT_OUT_EN] && !toggle_now // R21
        |=> $stable(toggle_output_out))
        else $error("Output changed with no toggle event.");

    chk_wrap_hold: assert property (wrap_flag_reg && !wr_mode |=> wrap_flag_reg) // R17
        else $error("Wrap flag dropped without a software clear.");
endmodule : ecct_timer

//--- hdl/ecct_pkg.sv
// Purpose: Shared constants of the edge clear capture timer.
// Assumes: Registers sit on a plain word port, one register per index.
// Notes:   Field positions are bit indices inside the listed registers.
package ecct_pkg;
    localparam int          ECCT_CNT_W        = 16;
    localparam int          ECCT_ADDR_W       = 3;
    localparam int          ECCT_DATA_W       = 16;
    // Register indices.
    localparam logic [2:0]  ECCT_ADDR_MODE    = 3'h0;
    localparam logic [2:0]  ECCT_ADDR_ROLE    = 3'h1;
    localparam logic [2:0]  ECCT_ADDR_OUTCTL  = 3'h2;
    localparam logic [2:0]  ECCT_ADDR_PRESC   = 3'h3;
    localparam logic [2:0]  ECCT_ADDR_COUNT   = 3'h4;
    localparam logic [2:0]  ECCT_ADDR_CC0     = 3'h5;
    localparam logic [2:0]  ECCT_ADDR_CC1     = 3'h6;
    // Mode control fields.
    localparam int          ECCT_MODE_WRAP    = 0;
    localparam int          ECCT_MODE_ETOG    = 1;
    localparam int          ECCT_MODE_LO      = 2;
    localparam int          ECCT_MODE_HI      = 3;
    // Capture role fields.
    localparam int          ECCT_ROLE_CAP0    = 0;
    localparam int          ECCT_ROLE_REV0    = 1;
    localparam int          ECCT_ROLE_CAP1    = 2;
    // Output control fields.
    localparam int          ECCT_OUT_EN       = 0;
    localparam int          ECCT_OUT_INV0     = 1;
    localparam int          ECCT_OUT_INV1     = 2;
    // Prescaler fields.
    localparam int          ECCT_PRE_SRC_LO   = 0;
    localparam int          ECCT_PRE_SRC_HI   = 1;
    localparam int          ECCT_PRE_A_LO     = 3;
    localparam int          ECCT_PRE_A_HI     = 4;
    localparam int          ECCT_PRE_B_LO     = 5;
    localparam int          ECCT_PRE_B_HI     = 6;
    // Operating modes.
    localparam logic [1:0]  ECCT_OP_STOP      = 2'h0;
    localparam logic [1:0]  ECCT_OP_FREE      = 2'h1;
    localparam logic [1:0]  ECCT_OP_EDGE_CLR  = 2'h2;
    localparam logic [1:0]  ECCT_OP_MATCH_CLR = 2'h3;
    // Edge selections.
    localparam logic [1:0]  ECCT_EDGE_FALL    = 2'h0;
    localparam logic [1:0]  ECCT_EDGE_RISE    = 2'h1;
    localparam logic [1:0]  ECCT_EDGE_NONE    = 2'h2;
    localparam logic [1:0]  ECCT_EDGE_BOTH    = 2'h3;
    // Count sources.
    localparam logic [1:0]  ECCT_SRC_EDGE_A   = 2'h3;
    localparam logic [15:0] ECCT_CNT_MAX      = 16'hffff;
    localparam logic [15:0] ECCT_CNT_ZERO     = 16'h0000;
endpackage : ecct_pkg

//--- hdl/ecct_edge_sync.sv
// Purpose: Synchronise one pin and report filtered rising and falling edges.
// Assumes: The pin is asynchronous to clock_in.
// Notes:   A level change counts only once two samples agree.
`timescale 1ns/100ps
module ecct_edge_sync (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_b_in,
    // Pin and edges
    input  wire logic pin_in,
    output logic      rise_out,
    output logic      fall_out
);
    logic       sync1_reg;
    logic       sync2_reg;
    logic       sync3_reg;
    logic       level_reg;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Short glitches never reach level_reg because both samples must agree.
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            level_reg <= 1'b0;
            rise_out  <= 1'b0;
            fall_out  <= 1'b0;
        end else begin
            rise_out <= 1'b0;
            fall_out <= 1'b0;
            if (sync2_reg == sync3_reg && sync3_reg != level_reg) begin // R22
                level_reg <= sync3_reg;
                rise_out  <= sync3_reg;
                fall_out  <= ~sync3_reg;
            end
        end
    end
endmodule : ecct_edge_sync

//--- tb/ecct_pin_model.sv
// Purpose: Outside pulse source that drives the two edge pins of the timer.
// Assumes: Levels change just after a rising clock edge.
// Notes:   A hold of one cycle makes a glitch that the input filter must drop.
`timescale 1ns/100ps
module ecct_pin_model (
    // Clock
    input  wire logic clock_in,
    // Pins
    output logic      pin_a_out,
    output logic      pin_b_out
);
    initial begin
        pin_a_out = 1'h0;
        pin_b_out = 1'h0;
    end

    // Long holds keep pin changes spaced so that each one is seen.
    task automatic drive(input bit sel_b, input logic lvl, input int hold);
        if (sel_b) begin
            pin_b_out <= lvl;
        end else begin
            pin_a_out <= lvl;
        end
        repeat (hold) @(posedge clock_in);
    endtask : drive
endmodule : ecct_pin_model

//--- tb/tb.sv
// Purpose: Self-checking bench for the edge clear capture timer.
// Assumes: Register reads return data one cycle after the strobe.
// Notes:   Captured counts are checked in windows because pin latency is a few cycles.
`timescale 1ns/100ps
module tb
    import ecct_pkg::*;
();
    logic                   clock_in   = 1'h0;
    logic                   rst_b_in   = 1'h0;
    logic [ECCT_ADDR_W-1:0] addr_in    = '0;
    logic [ECCT_DATA_W-1:0] wr_data_in = '0;
    logic                   wr_in      = 1'h0;
    logic                   rd_in      = 1'h0;
    logic [ECCT_DATA_W-1:0] rd_data_out;
    logic                   pin_a;
    logic                   pin_b;
    logic                   toggle_output_out;
    logic                   irq_zero_out;
    logic                   irq_one_out;
    logic                   tog_prev   = 1'h0;
    int                     err_total  = 0;
    int                     num_checks = 0;
    int                     cyc        = 0;
    int                     n_irq0     = 0;
    int                     n_irq1     = 0;
    int                     tog_q[$];

    ecct_timer i_ecct_timer (
        .clock_in          (clock_in),
        .rst_b_in          (rst_b_in),
        .addr_in           (addr_in),
        .wr_data_in        (wr_data_in),
        .wr_in             (wr_in),
        .rd_in             (rd_in),
        .rd_data_out       (rd_data_out),
        .edge_input_a_in   (pin_a),
        .edge_input_b_in   (pin_b),
        .toggle_output_out (toggle_output_out),
        .irq_zero_out      (irq_zero_out),
        .irq_one_out       (irq_one_out)
    );

    ecct_pin_model i_ecct_pin_model (
        .clock_in  (clock_in),
        .pin_a_out (pin_a),
        .pin_b_out (pin_b)
    );

    always #5 clock_in = ~clock_in;

    // Pulses are one cycle long, so each is counted exactly once here.
    always @(posedge clock_in) begin
        cyc = cyc + 1;
        if (irq_zero_out === 1'h1) n_irq0 = n_irq0 + 1;
        if (irq_one_out === 1'h1) n_irq1 = n_irq1 + 1;
        if (toggle_output_out !== tog_prev) tog_q.push_back(cyc);
        tog_prev = toggle_output_out;
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic chk_word(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_word

    task automatic chk_range(input string nm, input int lo, input int hi,
                             input logic [15:0] got);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'h1) begin
            err_total++;
            $display("ERROR %s expected %0d to %0d seen %h", nm, lo, hi, got);
        end
    endtask : chk_range

    task automatic chk_count(input string nm, input int exp, input int got);
        num_checks++;
        if (got != exp) begin
            err_total++;
            $display("ERROR %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_count

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        addr_in    <= a;
        wr_data_in <= d;
        wr_in      <= 1'h1;
        @(posedge clock_in);
        wr_in <= 1'h0;
        @(posedge clock_in);
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        addr_in <= a;
        rd_in   <= 1'h1;
        @(posedge clock_in);
        rd_in <= 1'h0;
        #1 d = rd_data_out;
        @(posedge clock_in);
    endtask : rd

    task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp, input string nm);
        logic [15:0] v;
        rd(a, v);
        chk_word(nm, exp, v);
    endtask : rd_chk

    initial begin
        logic [15:0] v;
        logic [15:0] c_ref;
        logic [15:0] c_cap;
        int          k;
        repeat (16) @(posedge clock_in);
        rst_b_in <= 1'h1;
        @(posedge clock_in);
        rd_chk(ECCT_ADDR_COUNT, 16'h0000, "count");
        rd_chk(ECCT_ADDR_MODE, 16'h0000, "mode");
        rd_chk(3'h7, 16'h0000, "unmapped");
        chk_word("toggle", 16'h0000, {15'h0000, toggle_output_out});
        wr(ECCT_ADDR_COUNT, 16'h1234);
        rd_chk(ECCT_ADDR_COUNT, 16'h0000, "count ro");
        // Free running with both registers comparing; matches must not stop the wrap.
        wr(ECCT_ADDR_CC0, 16'h8000);
        wr(ECCT_ADDR_CC1, 16'h9000);
        wr(ECCT_ADDR_OUTCTL, 16'h0007);
        n_irq0 = 0;
        n_irq1 = 0;
        tog_q.delete();
        wr(ECCT_ADDR_MODE, 16'h0004);
        rd(ECCT_ADDR_COUNT, c_ref);
        rd(ECCT_ADDR_COUNT, v);
        chk_word("count step", c_ref + 16'h0002, v);
        k = 0;
        v = 16'h0000;
        while (v[ECCT_MODE_WRAP] !== 1'h1 && k < 40000) begin
            rd(ECCT_ADDR_MODE, v);
            k++;
        end
        if (v[ECCT_MODE_WRAP] !== 1'h1) begin
            err_total++;
            $display("ERROR wrap flag expected 1 seen 0");
            give_verdict();
        end
        rd(ECCT_ADDR_COUNT, c_ref);
        chk_range("count wrap", 0, 8, c_ref);
        chk_count("irq zero match", 1, n_irq0);
        chk_count("irq one match", 1, n_irq1);
        chk_count("match toggles", 2, tog_q.size());
        wr(ECCT_ADDR_MODE, 16'h0004);
        rd_chk(ECCT_ADDR_MODE, 16'h0004, "wrap cleared");
        // Edge clear with register one capturing and toggle on edge.
        wr(ECCT_ADDR_PRESC, 16'h0048);
        wr(ECCT_ADDR_ROLE, 16'h0004);
        wr(ECCT_ADDR_OUTCTL, 16'h0003);
        wr(ECCT_ADDR_CC0, 16'h0003);
        wr(ECCT_ADDR_MODE, 16'h000a);
        repeat (20) @(posedge clock_in);
        n_irq1 = 0;
        i_ecct_pin_model.drive(1'h0, 1'h1, 1);
        i_ecct_pin_model.drive(1'h0, 1'h0, 12);
        chk_count("glitch", 0, n_irq1);
        rd(ECCT_ADDR_COUNT, c_ref);
        n_irq0 = 0;
        tog_q.delete();
        i_ecct_pin_model.drive(1'h0, 1'h1, 1);
        k = 0;
        while (n_irq1 == 0 && k < 50) begin
            @(posedge clock_in);
            k++;
        end
        if (k == 50) begin
            err_total++;
            $display("ERROR irq one expected pulse seen none");
            give_verdict();
        end
        rd(ECCT_ADDR_COUNT, v);
        chk_range("count cleared", 0, 8, v);
        rd(ECCT_ADDR_CC1, c_cap);
        chk_range("capture one", int'(c_ref) + 2, int'(c_ref) + 14, c_cap);
        i_ecct_pin_model.drive(1'h0, 1'h0, 12);
        chk_count("irq one rise only", 1, n_irq1);
        chk_count("irq zero match", 1, n_irq0);
        chk_count("edge toggles", 2, tog_q.size());
        if (tog_q.size() == 2) chk_count("pulse width", 4, tog_q[1] - tog_q[0]);
        // Reverse phase capture into register zero; output left unused.
        wr(ECCT_ADDR_OUTCTL, 16'h0000);
        wr(ECCT_ADDR_CC1, 16'hf000);
        wr(ECCT_ADDR_PRESC, 16'h0028);
        wr(ECCT_ADDR_ROLE, 16'h0003);
        n_irq0 = 0;
        i_ecct_pin_model.drive(1'h0, 1'h1, 40);
        i_ecct_pin_model.drive(1'h0, 1'h0, 12);
        rd(ECCT_ADDR_CC0, c_cap);
        chk_range("capture zero", 36, 44, c_cap);
        chk_count("irq zero reverse", 0, n_irq0);
        i_ecct_pin_model.drive(1'h1, 1'h1, 12);
        rd_chk(ECCT_ADDR_CC0, c_cap, "capture zero held");
        chk_count("irq zero input b", 1, n_irq0);
        // Both edges of input A capture, clear and toggle.
        wr(ECCT_ADDR_OUTCTL, 16'h0001);
        wr(ECCT_ADDR_PRESC, 16'h0058);
        wr(ECCT_ADDR_ROLE, 16'h0005);
        n_irq1 = 0;
        tog_q.delete();
        i_ecct_pin_model.drive(1'h0, 1'h1, 30);
        i_ecct_pin_model.drive(1'h0, 1'h0, 12);
        rd(ECCT_ADDR_CC1, c_cap);
        chk_range("capture both", 26, 34, c_cap);
        chk_count("irq one both", 2, n_irq1);
        chk_count("toggles both", 2, tog_q.size());
        // Free running with both capturing; input B feeds register zero.
        wr(ECCT_ADDR_MODE, 16'h0004);
        wr(ECCT_ADDR_PRESC, 16'h0028);
        i_ecct_pin_model.drive(1'h1, 1'h0, 12);
        n_irq0 = 0;
        i_ecct_pin_model.drive(1'h1, 1'h1, 12);
        rd(ECCT_ADDR_CC0, c_cap);
        rd(ECCT_ADDR_COUNT, v);
        chk_range("free capture", int'(c_cap) + 4, int'(c_cap) + 20, v);
        chk_count("irq zero free", 1, n_irq0);
        give_verdict();
    end
endmodule : tb
